// ### tb/sswd_proc_model.sv
/*
 * Processor-side model: drives the three-level watchdog service pair
 * and the external time base clock.
 * Assumes one reference clock; mode picked by the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module sswd_proc_model (
    input wire logic i_ref_clk,
    input wire logic [1:0] i_mode,
    input wire logic i_ext_run,
    output var logic o_wd_high,
    output var logic o_wd_low,
    output var logic o_ext_clk
);
    // =====================================================
    // service toggle, well inside the short timeout
    int unsigned tgl_cnt = 0;
    int unsigned ext_cnt = 0;
    logic level = 1'b0;
    always @(posedge i_ref_clk) begin
        tgl_cnt <= (tgl_cnt == 999) ? 0 : tgl_cnt + 1;
        if (tgl_cnt == 999) begin
            level <= ~level;
        end
        ext_cnt <= i_ext_run ? ext_cnt + 1 : 0;
    end
    always_comb begin
        case (i_mode)
            2'd1: {o_wd_high, o_wd_low} = {level, ~level};
            2'd2: {o_wd_high, o_wd_low} = 2'b10;
            2'd3: {o_wd_high, o_wd_low} = 2'b01;
            default: {o_wd_high, o_wd_low} = 2'b00;
        endcase
    end
    // period of 4 cycles; stands low when stopped
    always_comb begin
        o_ext_clk = i_ext_run & ext_cnt[1];
    end
endmodule

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench for the supervisor: supply, watchdog, gating,
 * bus and time base scenarios with seeded random levels.
 * Assumes the processor model sits in its own file.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sup_low = 1'b0, below = 1'b0, sense = 1'b0, ce_in = 1'b1;
    logic sel = 1'b1, ext_lvl = 1'b0, ext_run = 1'b0, ext_clk, ext_in;
    logic wd_h, wd_l, rd = 1'b0, wr = 1'b0, rstn_o, rst_o, exp_n;
    logic pfo_n, ce_n, batt, low_n, waitreq;
    logic [1:0] mode = 2'd0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    int bad_count = 0, tests_run = 0, cyc = 0, n, i;

    // =====================================================
    // clock, time base mux, design and partner
    initial forever #4 clk = ~clk;
    assign ext_in = sel ? ext_lvl : ext_clk;
    sswd_top #(.INT_TICK(4)) i_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_supply_low(sup_low), .i_below_battery(below),
        .i_powerfail_sense_in(sense), .i_chip_enable_n(ce_in),
        .i_timebase_select(sel), .i_ext_timebase_in(ext_in),
        .i_watchdog_service_in_high(wd_h),
        .i_watchdog_service_in_low(wd_l), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_reset_n(rstn_o), .o_reset(rst_o), .o_watchdog_expired_n(exp_n),
        .o_powerfail_warn_n(pfo_n), .o_chip_enable_n(ce_n),
        .o_battery_active(batt), .o_low_supply_n(low_n));
    sswd_proc_model i_proc (.i_ref_clk(clk), .i_mode(mode),
        .i_ext_run(ext_run), .o_wd_high(wd_h), .o_wd_low(wd_l),
        .o_ext_clk(ext_clk));

    // =====================================================
    // checking helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // counts edges until the chosen output reaches val
    task automatic wait_for(input int s, input logic v, input int lim);
        n = 0;
        while (((s == 0) ? rstn_o : exp_n) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        addr <= a;
        wdata <= wd;
        rd <= ~w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'b0) begin
            @(posedge clk);
        end
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // supply dip, then edges until reset releases
    task automatic dip(input int lim);
        sup_low <= 1'b1;
        tick(6);
        sup_low <= 1'b0;
        tick(5);
        chk(32'(low_n), 32'h1);
        chk(32'(rstn_o), 32'h0);
        wait_for(0, 1'b1, lim);
    endtask
    function automatic logic [2:0] expect_lv(logic s, logic c, logic b);
        return {~(s | b), c | b, b};
    endfunction
    task automatic done(input string s);
        $display("test %s done, mismatches %0d", s, bad_count);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n && rst_o !== ~rstn_o) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rst_o,
                ~rstn_o);
        end
        if (cyc == 90000) begin
            bad_count++;
            wrap_up();
        end
    end

    // =====================================================
    // main sequence
    initial begin
        void'($urandom(34846));
        tick(16);
        chk({rstn_o, rst_o, exp_n, pfo_n, ce_n, batt, low_n}, 7'h34);
        rst_n <= 1'b1;
        wait_for(0, 1'b1, 3000);
        rng(n, 1990, 2030);
        done("powerup");
        sup_low <= 1'b1;
        tick(5);
        chk({rstn_o, low_n, ce_n, exp_n}, 4'h3);
        sup_low <= 1'b0;
        tick(5);
        chk(32'(low_n), 32'h1);
        wait_for(0, 1'b1, 2100);
        rng(n, 1980, 2030);
        done("dip");
        for (i = 0; i < 40; i++) begin
            sense <= 1'($urandom);
            ce_in <= 1'($urandom);
            below <= ($urandom % 4) == 0;
            tick(5);
            d = 32'(expect_lv(sense, ce_in, below));
            chk({pfo_n, ce_n, batt}, d);
        end
        below <= 1'b0;
        sense <= 1'b0;
        ce_in <= 1'b1;
        wait_for(0, 1'b1, 2200);
        done("random");
        mode <= 2'd1;
        wait_for(1, 1'b0, 10000);
        chk(n, 10000);
        // pass through mid so the count starts from a known point
        mode <= 2'd0;
        tick(5);
        mode <= 2'd2;
        wait_for(1, 1'b0, 4200);
        rng(n, 3985, 4025);
        tick(5);
        chk(32'(rstn_o), 32'h0);
        wait_for(0, 1'b1, 2100);
        rng(n, 1985, 2010);
        wait_for(0, 1'b0, 2100);
        rng(n, 1985, 2015);
        chk(32'(exp_n), 32'h0);
        mode <= 2'd3;
        tick(5);
        chk(32'(exp_n), 32'h1);
        wait_for(1, 1'b0, 4200);
        rng(n, 3975, 4025);
        sup_low <= 1'b1;
        tick(5);
        chk(32'(exp_n), 32'h1);
        sup_low <= 1'b0;
        wait_for(0, 1'b1, 2100);
        done("watchdog");
        mode <= 2'd0;
        wait_for(1, 1'b0, 5000);
        chk(n, 5000);
        ext_lvl <= 1'b1;
        mode <= 2'd2;
        wait_for(1, 1'b0, 6000);
        chk(n, 6000);
        mode <= 2'd0;
        ext_lvl <= 1'b0;
        done("levels");
        bus(1'b1, sswd_pkg::REG_CTRL, 32'h1);
        bus(1'b0, sswd_pkg::REG_CTRL, 32'h0);
        chk(d, 32'h1);
        bus(1'b0, sswd_pkg::REG_EXPIRIES, 32'h0);
        chk(d, 32'h3);
        bus(1'b1, sswd_pkg::REG_EXPIRIES, 32'h0);
        bus(1'b0, sswd_pkg::REG_EXPIRIES, 32'h0);
        chk(d, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        chk(d, 32'h0);
        bus(1'b0, sswd_pkg::REG_STATUS, 32'h0);
        chk(d, {24'h0, 1'b1, sel, ce_in, below, 1'b1, ~sense, 2'b11});
        done("bus");
        dip(8100);
        rng(n, 7970, 8030);
        bus(1'b1, sswd_pkg::REG_CTRL, 32'h0);
        done("long hold");
        ext_run <= 1'b1;
        sel <= 1'b0;
        tick(20);
        dip(4500);
        rng(n, 4060, 4130);
        mode <= 2'd2;
        wait_for(1, 1'b0, 17000);
        rng(n, 15360, 16400);
        mode <= 2'd0;
        sel <= 1'b1;
        ext_run <= 1'b0;
        done("external");
        wrap_up();
    end
endmodule

`default_nettype wire

// ### verilog/sswd_pkg.sv
/*
 * Constants shared by the supply supervisor and watchdog reset block:
 * time base, hold and timeout counts, register map and reset states.
 * Assumes a single 125 MHz clock; comparator decisions arrive as levels.
 */
//
// Operation
// - reset low while supply below threshold or battery
// - hold reset low 50/200 ms after recovery
// - unserviced enabled watchdog pulses reset for hold time
// - watchdog input three-level; mid or floating disables timer
// - every watchdog input transition restarts the timeout
// - expired flag low after unchanged input past timeout
// - expired flag stays low until next input transition
// - expired flag high while watchdog input is mid
// - expired flag forced high when low-supply goes low
// - power-fail warning low while sense below 1.3 V
// - below battery disables comparator, warning held low
// - chip-enable out low only if input low, supply good
// - battery-active high while backed-up supply uses battery
// - low-supply flag follows threshold, no hold delay
// - active-high reset always inverse of active-low reset
// - select high or floating uses internal oscillator timing
// - select low times hold and timeout from external clock
// - internal mode: external input level picks short/long timeout
// - internal long timeout 1.6 s, short 100 ms
// - external long 3840..4097 cycles, short 768..1025 cycles; the code always uses the long count of 4096 in external mode
// - reset pulse repeats each timeout until serviced
`default_nettype none

package sswd_pkg;
    // =====================================================
    // time base
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 100;
    localparam int INT_TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int HOLD_SHORT_MS = 50;
    localparam int HOLD_LONG_MS = 200;
    localparam int WD_LONG_MS = 1600;
    localparam int WD_SHORT_MS = 100;
    localparam logic [15:0] HOLD_SHORT_TICKS =
        16'(HOLD_SHORT_MS * 1000 / TICK_US);
    localparam logic [15:0] HOLD_LONG_TICKS =
        16'(HOLD_LONG_MS * 1000 / TICK_US);
    localparam logic [15:0] WD_LONG_TICKS = 16'(WD_LONG_MS * 1000 / TICK_US);
    localparam logic [15:0] WD_SHORT_TICKS =
        16'(WD_SHORT_MS * 1000 / TICK_US);
    // external clock counts, in clock cycles
    localparam logic [15:0] EXT_WD_LONG = 16'h1000;
    localparam logic [15:0] EXT_WD_SHORT = 16'h0400;
    localparam logic [15:0] EXT_HOLD_SHORT = 16'h0400;
    localparam logic [15:0] EXT_HOLD_LONG = 16'h1000;

    // =====================================================
    // register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_EXPIRIES = 4'h8;
    localparam int CTRL_LONG_HOLD = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int ST_RESET_N = 0;
    localparam int ST_WDO_N = 1;
    localparam int ST_PFO_N = 2;
    localparam int ST_LOW_N = 3;
    localparam int ST_BATT = 4;
    localparam int ST_CE_N = 5;
    localparam int ST_INT_OSC = 6;
    localparam int ST_WD_MID = 7;

    // =====================================================
    // reset sequencer states, gray along bad -> hold -> run
    typedef enum logic [1:0] {
        RS_SUPPLY_BAD = 2'b00,
        RS_HOLD = 2'b01,
        RS_RUN = 2'b11
    } sswd_rst_state_t;
endpackage

`default_nettype wire

// ### verilog/sswd_sync.sv
/*
 * Two-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; no word coherence is implied.
 */
`timescale 1ns/1ns
`default_nettype none

module sswd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output var logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

`default_nettype wire

// ### verilog/sswd_top.sv
/*
 * Supply supervisor with watchdog: reset generation, watchdog expiry,
 * power-fail warning, chip-enable gating, battery-active flag, and an
 * Avalon-MM slave for control and status.
 * Assumes analog comparators and the supply switch sit outside and
 * deliver their decisions as asynchronous levels.
 */
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module sswd_top #(
    parameter int INT_TICK = sswd_pkg::INT_TICK_CYCLES,
    parameter bit LONG_HOLD_DEFAULT = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_supply_low,
    input wire logic i_below_battery,
    input wire logic i_powerfail_sense_in,
    input wire logic i_chip_enable_n,
    input wire logic i_timebase_select,
    input wire logic i_ext_timebase_in,
    input wire logic i_watchdog_service_in_high,
    input wire logic i_watchdog_service_in_low,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output var logic [31:0] o_avs_readdata,
    output var logic o_avs_waitrequest,
    output var logic o_reset_n,
    output var logic o_reset,
    output var logic o_watchdog_expired_n,
    output var logic o_powerfail_warn_n,
    output var logic o_chip_enable_n,
    output var logic o_battery_active,
    output var logic o_low_supply_n
);
    // =====================================================
    // pin synchronisation
    logic [7:0] pins_sync;
    logic supply_bad, below_batt, pf_low, ce_in_n;
    logic int_osc, ext_level, wdi_hi, wdi_lo;

    // reset levels read as supply bad, chip disabled, watchdog mid:
    // nothing is enabled before the real pin levels have arrived
    sswd_sync #(.WIDTH(8), .RESET_VAL(8'hb8)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_supply_low, i_below_battery, i_powerfail_sense_in,
                  i_chip_enable_n, i_timebase_select, i_ext_timebase_in,
                  i_watchdog_service_in_high, i_watchdog_service_in_low}),
        .o_sync(pins_sync)
    );

    // below battery implies below threshold as well
    assign supply_bad = pins_sync[7] | pins_sync[6];
    assign below_batt = pins_sync[6];
    assign pf_low = pins_sync[5];
    assign ce_in_n = pins_sync[4];
    assign int_osc = pins_sync[3];
    assign ext_level = pins_sync[2];
    assign wdi_hi = pins_sync[1];
    assign wdi_lo = pins_sync[0];

    // =====================================================
    // time base
    logic [15:0] div_cnt;
    logic int_tick, ext_prev, ext_rise, tick;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_cnt <= 16'h0000;
            int_tick <= 1'b0;
        end else if (div_cnt == 16'(INT_TICK - 1)) begin
            div_cnt <= 16'h0000;
            int_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            int_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_level;
        end
    end

    assign ext_rise = ext_level & ~ext_prev;
    assign tick = int_osc ? int_tick : ext_rise;

    // =====================================================
    // control register and count targets
    logic [31:0] ctrl;
    logic long_hold;
    logic [15:0] hold_target, wd_target;

    assign long_hold = ctrl[sswd_pkg::CTRL_LONG_HOLD];

    always_comb begin
        if (int_osc) begin
            hold_target = long_hold ? sswd_pkg::HOLD_LONG_TICKS
                                    : sswd_pkg::HOLD_SHORT_TICKS;
            // unconnected external time base input floats high: long period
            wd_target = ext_level ? sswd_pkg::WD_LONG_TICKS
                                  : sswd_pkg::WD_SHORT_TICKS;
        end else begin
            hold_target = long_hold ? sswd_pkg::EXT_HOLD_LONG
                                    : sswd_pkg::EXT_HOLD_SHORT;
            // external mode always uses the long count
            wd_target = sswd_pkg::EXT_WD_LONG;
        end
    end

    // =====================================================
    // watchdog input classification and timer
    logic wd_mid, wd_last, wd_last_mid, wd_edge, wd_expire;
    logic [15:0] wd_cnt;

    assign wd_mid = ~(wdi_hi ^ wdi_lo);
    // leaving mid is not a service edge: timer already cleared
    assign wd_edge = ~wd_mid & ~wd_last_mid & (wdi_hi != wd_last);
    assign wd_expire = tick & ~wd_mid & ~wd_edge & ~supply_bad &
                       (wd_cnt == wd_target - 16'h0001);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wd_last <= 1'b0;
            wd_last_mid <= 1'b1;
        end else begin
            wd_last <= wdi_hi;
            wd_last_mid <= wd_mid;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wd_cnt <= 16'h0000;
        end else if (wd_mid || wd_edge || supply_bad) begin
            wd_cnt <= 16'h0000;
        end else if (wd_expire) begin
            wd_cnt <= 16'h0000; // restart for the next pulse
        end else if (tick) begin
            wd_cnt <= wd_cnt + 16'h0001;
        end
    end

    // expired flag: low on expiry, high on edge, mid or low supply
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_watchdog_expired_n <= 1'b1;
        end else if (wd_mid || wd_edge || supply_bad) begin
            o_watchdog_expired_n <= 1'b1;
        end else if (wd_expire) begin
            o_watchdog_expired_n <= 1'b0;
        end
    end

    // =====================================================
    // reset sequencer
    sswd_pkg::sswd_rst_state_t st, next_st;
    logic [15:0] hold_cnt;

    always_comb begin
        next_st = st;
        unique case (st)
            sswd_pkg::RS_SUPPLY_BAD: begin
                if (!supply_bad) begin
                    next_st = sswd_pkg::RS_HOLD;
                end
            end
            sswd_pkg::RS_HOLD: begin
                if (tick && hold_cnt == hold_target - 16'h0001) begin
                    next_st = sswd_pkg::RS_RUN;
                end
            end
            sswd_pkg::RS_RUN: begin
                if (wd_expire) begin
                    next_st = sswd_pkg::RS_HOLD;
                end
            end
            default: next_st = sswd_pkg::RS_SUPPLY_BAD;
        endcase
        if (supply_bad) begin
            next_st = sswd_pkg::RS_SUPPLY_BAD;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st <= sswd_pkg::RS_SUPPLY_BAD;
            o_reset_n <= 1'b0;
            o_reset <= 1'b1;
        end else begin
            st <= next_st;
            o_reset_n <= (next_st == sswd_pkg::RS_RUN);
            o_reset <= (next_st != sswd_pkg::RS_RUN);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            hold_cnt <= 16'h0000;
        end else if (next_st != sswd_pkg::RS_HOLD ||
                     st != sswd_pkg::RS_HOLD) begin
            hold_cnt <= 16'h0000;
        end else if (tick) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    // =====================================================
    // supply-derived outputs, no hold delay on any of them
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_powerfail_warn_n <= 1'b0;
            o_chip_enable_n <= 1'b1;
            o_battery_active <= 1'b0;
            o_low_supply_n <= 1'b0;
        end else begin
            o_powerfail_warn_n <= ~(pf_low | below_batt);
            o_chip_enable_n <= ce_in_n | supply_bad;
            o_battery_active <= below_batt;
            o_low_supply_n <= ~supply_bad;
        end
    end

    // =====================================================
    // Avalon-MM slave: one wait cycle, then answer
    logic req, accept;
    logic [15:0] expiries;
    logic [31:0] status, rd_mux;

    assign req = i_avs_read | i_avs_write;
    assign accept = req & ~o_avs_waitrequest;

    always_comb begin
        status = 32'h0000_0000;
        status[sswd_pkg::ST_RESET_N] = o_reset_n;
        status[sswd_pkg::ST_WDO_N] = o_watchdog_expired_n;
        status[sswd_pkg::ST_PFO_N] = o_powerfail_warn_n;
        status[sswd_pkg::ST_LOW_N] = o_low_supply_n;
        status[sswd_pkg::ST_BATT] = o_battery_active;
        status[sswd_pkg::ST_CE_N] = o_chip_enable_n;
        status[sswd_pkg::ST_INT_OSC] = int_osc;
        status[sswd_pkg::ST_WD_MID] = wd_mid;
        unique case (i_avs_address)
            sswd_pkg::REG_CTRL: rd_mux = ctrl;
            sswd_pkg::REG_STATUS: rd_mux = status;
            sswd_pkg::REG_EXPIRIES: rd_mux = {16'h0000, expiries};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl <= sswd_pkg::CTRL_RESET |
                    {31'h0000_0000, LONG_HOLD_DEFAULT};
        end else if (accept && i_avs_write &&
                     i_avs_address == sswd_pkg::REG_CTRL) begin
            ctrl <= {31'h0000_0000, i_avs_writedata[0]};
        end
    end

    // write clears; an expiry in the same cycle still counts
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            expiries <= 16'h0000;
        end else if (wd_expire) begin
            if (accept && i_avs_write &&
                i_avs_address == sswd_pkg::REG_EXPIRIES) begin
                expiries <= 16'h0001;
            end else if (expiries != 16'hffff) begin
                expiries <= expiries + 16'h0001;
            end
        end else if (accept && i_avs_write &&
                     i_avs_address == sswd_pkg::REG_EXPIRIES) begin
            expiries <= 16'h0000;
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_RST_BAD: assert property (supply_bad |=> !o_reset_n)
        else $error("reset released with supply bad");
    AST_RST_HOLD: assert property ($rose(o_reset_n) |->
        $past(st) == sswd_pkg::RS_HOLD && $past(tick) &&
        $past(hold_cnt) == $past(hold_target) - 16'h0001)
        else $error("reset released before hold time");
    AST_WD_PULSE: assert property (wd_expire |=>
        !o_reset_n && st == sswd_pkg::RS_HOLD ##1 hold_cnt == 16'h0000)
        else $error("watchdog expiry did not start reset pulse");
    AST_WD_MID: assert property (wd_mid |=>
        wd_cnt == 16'h0000 && o_watchdog_expired_n)
        else $error("watchdog active while input mid");
    AST_WD_RESTART: assert property (wd_edge |=> wd_cnt == 16'h0000)
        else $error("transition did not restart timer");
    AST_WDO_LOW: assert property (wd_expire |=> !o_watchdog_expired_n)
        else $error("expired flag not set on timeout");
    AST_WDO_STICK: assert property (!o_watchdog_expired_n && !wd_edge &&
        !wd_mid && !supply_bad |=> !o_watchdog_expired_n)
        else $error("expired flag left low without transition");
    AST_WDO_LOWLINE: assert property (!o_low_supply_n |->
        o_watchdog_expired_n)
        else $error("expired flag low while supply low");
    AST_PFO: assert property ((pf_low || below_batt) |=>
        !o_powerfail_warn_n)
        else $error("power-fail warning not asserted");
    AST_CE: assert property (!o_chip_enable_n |->
        $past(!ce_in_n) && $past(!supply_bad))
        else $error("chip enable passed while not allowed");
    AST_LOWLINE: assert property (o_low_supply_n ==
        $past(!supply_bad))
        else $error("low-supply flag wrong");
    AST_RST_INV: assert property (o_reset == !o_reset_n)
        else $error("reset outputs not complementary");
    AST_BATT: assert property (o_battery_active == $past(below_batt))
        else $error("battery-active flag wrong");

    COV_RECOVER: cover property ($rose(o_reset_n));
    COV_EXPIRE: cover property (wd_expire);
    COV_SERVICE: cover property (!o_watchdog_expired_n ##1 wd_edge);
    COV_BUS_WRITE: cover property (accept && i_avs_write);
endmodule

`default_nettype wire
